/* File: src/uifs_core.sv */
// UART interrupt sources, receive FIFO, serial port and shutdown sequencing
`timescale 1ns/10ps
// Function
// - Parity flag set when enabled and bit one
// - Parity interrupt follows oldest FIFO word
// - Data flag holds interrupt while masked in
// - Line transition in shutdown sets activity flag
// - Stop bit zero sets framing flag
// - Buffer empty with mask drives interrupt low
// - Sixteenth data-op clock clears empty source
// - Eight-word FIFO, flushed on overflow, shutdown
// - FIFO on at power-up, host may disable
// - Hardware shutdown immediate, aborts transmit, stops oscillator
// - Software shutdown waits for transmit drain
// - Shutdown status set on either entry
// - Entry clears FIFO, flags; empty forced
// - Settings still accepted while shut down
// - Wake write restarts oscillator at select release
// - Configuration write resets all but handshake
// - Data operations release interrupt when causes gone
module uifs_core #(
   parameter int OSC_START_CYCLES = uifs_pkg::OSC_START_CYC,
   parameter int RX_FIFO_DEPTH    = uifs_pkg::FIFO_DEPTH
) (
   input  wire logic                       clock,
   input  wire logic                       rst_b,
   input  wire logic                       sclk,
   input  wire logic                       cs_n,
   input  wire logic                       din,
   output logic                            dout,
   input  wire logic                       hw_sleep_n,
   input  wire logic                       rx_line,
   input  wire logic                       cts_n,
   input  wire logic                       rx_char_valid,
   input  wire uifs_pkg::uifs_rx_word_type rx_char,
   input  wire logic                       rx_frame_err,
   input  wire logic                       tx_take,
   input  wire logic                       tx_shift_busy,
   output logic                            tx_valid,
   output uifs_pkg::uifs_rx_word_type      tx_char,
   output logic                            tx_abort,
   output logic                            rts_n,
   output logic                            irq_n,
   output logic                            osc_run,
   output logic                            osc_ready,
   output logic                            sleep_status,
   output uifs_pkg::uifs_cfg_type          cfg
);
   localparam int OSC_W = $clog2(OSC_START_CYCLES + 1);

   // The settle counter needs at least one cycle to mean anything
   if (OSC_START_CYCLES < 1 || RX_FIFO_DEPTH < 2) begin : g_bad_param
      $error("uifs_core: OSC_START_CYCLES >= 1 and RX_FIFO_DEPTH >= 2 required");
   end

   // Pin synchronisers: three stages, a change counts once stages two and three agree
   logic [uifs_pkg::PIN_N-1:0] s1_q;       // First stage, read only by s2_q
   logic [uifs_pkg::PIN_N-1:0] s2_q;       // Second stage
   logic [uifs_pkg::PIN_N-1:0] s3_q;       // Third stage
   logic [uifs_pkg::PIN_N-1:0] pin_q;      // Filtered pin levels
   logic [uifs_pkg::PIN_N-1:0] pin_prev_q; // Levels one cycle ago

   wire [uifs_pkg::PIN_N-1:0] pin_raw  = {cts_n, rx_line, hw_sleep_n, din, cs_n, sclk};
   wire [uifs_pkg::PIN_N-1:0] pin_diff = s2_q ^ s3_q;
   wire [uifs_pkg::PIN_N-1:0] pin_d    = (s2_q & ~pin_diff) | (pin_q & pin_diff);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s1_q       <= uifs_pkg::PIN_IDLE;
         s2_q       <= uifs_pkg::PIN_IDLE;
         s3_q       <= uifs_pkg::PIN_IDLE;
         pin_q      <= uifs_pkg::PIN_IDLE;
         pin_prev_q <= uifs_pkg::PIN_IDLE;
      end else begin
         s1_q       <= pin_raw;
         s2_q       <= s1_q;
         s3_q       <= s2_q;
         pin_q      <= pin_d;
         pin_prev_q <= pin_q;
      end
   end

   // Edge and level decode of the filtered pins
   wire in_frame  = ~pin_q[uifs_pkg::PIN_CS_N];
   wire cs_fall   = in_frame & pin_prev_q[uifs_pkg::PIN_CS_N];
   wire cs_rise   = ~in_frame & ~pin_prev_q[uifs_pkg::PIN_CS_N];
   wire sclk_rise = pin_q[uifs_pkg::PIN_SCLK] & ~pin_prev_q[uifs_pkg::PIN_SCLK];
   wire sclk_fall = ~pin_q[uifs_pkg::PIN_SCLK] & pin_prev_q[uifs_pkg::PIN_SCLK];
   wire rx_edge   = pin_q[uifs_pkg::PIN_RX] ^ pin_prev_q[uifs_pkg::PIN_RX];
   wire hw_low    = ~pin_q[uifs_pkg::PIN_HW_N];

   // Serial port state
   logic [uifs_pkg::BIT_CNT_W-1:0] bit_cnt_q;   // Rising edges seen this frame
   logic [uifs_pkg::WORD_BITS-1:0] in_sr_q;     // Word from host
   logic [uifs_pkg::WORD_BITS-1:0] out_sr_q;    // Word to host
   logic                           dout_q;      // Serial output bit

   // Block state
   uifs_pkg::uifs_pwr_type     pwr_q;       // Power sequencing
   uifs_pkg::uifs_cfg_type     cfg_q;       // Configuration settings
   uifs_pkg::uifs_rx_word_type tx_char_q;   // Transmit buffer contents
   logic                       tx_full_q;   // Transmit buffer occupied
   logic                       tx_src_q;    // Buffer-empty interrupt source
   logic                       act_fe_q;    // Activity or framing error flag
   logic                       rts_n_q;     // Handshake output
   logic                       abort_q;     // Transmit abort pulse
   logic                       irq_n_q;     // Interrupt output
   logic                       osc_run_q;   // Oscillator enable
   logic                       osc_ready_q; // Oscillator settled
   logic                       sleep_q;     // Shutdown status
   logic [OSC_W-1:0]           osc_cnt_q;   // Settle counter

   // Frame decode
   wire       bit_in    = pin_q[uifs_pkg::PIN_DIN];
   wire [15:0] word_d   = {in_sr_q[14:0], bit_in};
   wire       take_bit  = in_frame & sclk_rise & (bit_cnt_q != uifs_pkg::CNT_FULL);
   wire       last_rise = take_bit & (bit_cnt_q == uifs_pkg::CNT_LAST);
   wire       cfg_read  = take_bit & (bit_cnt_q == uifs_pkg::CNT_CMD_DONE)
                          & (word_d[1:0] == uifs_pkg::UIFS_RD_CFG);
   wire       data_op16 = last_rise & ~word_d[14];
   wire       frame_ok  = cs_rise & (bit_cnt_q == uifs_pkg::CNT_FULL);
   wire       cfg_wr    = frame_ok & (in_sr_q[15:14] == uifs_pkg::UIFS_WR_CFG);
   wire       data_wr   = frame_ok & (in_sr_q[15:14] == uifs_pkg::UIFS_WR_DATA);
   wire uifs_pkg::uifs_cfg_type new_cfg = uifs_pkg::uifs_cfg_type'(in_sr_q[13:0]);

   // Power sequencing decode
   uifs_pkg::uifs_pwr_type pwr_d;
   always_comb begin
      pwr_d = pwr_q;
      unique case (pwr_q)
         uifs_pkg::UIFS_PWR_RUN: begin
            if (hw_low) begin
               pwr_d = uifs_pkg::UIFS_PWR_SLEEP;
            end else if (cfg_q.sw_sleep_request) begin
               pwr_d = uifs_pkg::UIFS_PWR_DRAIN;
            end
         end
         uifs_pkg::UIFS_PWR_DRAIN: begin
            if (hw_low) begin
               pwr_d = uifs_pkg::UIFS_PWR_SLEEP;
            end else if (!cfg_q.sw_sleep_request) begin
               pwr_d = uifs_pkg::UIFS_PWR_RUN;
            end else if (!tx_full_q && !tx_shift_busy) begin
               pwr_d = uifs_pkg::UIFS_PWR_SLEEP;
            end
         end
         uifs_pkg::UIFS_PWR_SLEEP: begin
            if (cfg_wr && !new_cfg.sw_sleep_request && !hw_low) begin
               pwr_d = uifs_pkg::UIFS_PWR_RUN;
            end
         end
         default: pwr_d = uifs_pkg::UIFS_PWR_SLEEP;
      endcase
   end

   wire asleep    = (pwr_q == uifs_pkg::UIFS_PWR_SLEEP);
   wire enter     = (pwr_d == uifs_pkg::UIFS_PWR_SLEEP) & ~asleep;
   wire leave     = asleep & (pwr_d != uifs_pkg::UIFS_PWR_SLEEP);
   wire clear_all = enter | cfg_wr;

   // Receive FIFO hookup; overflow or a disabled FIFO replaces old contents
   logic                       fifo_in_ready;
   logic                       fifo_valid;
   uifs_pkg::uifs_rx_word_type fifo_head;
   // A character landing with a configuration write survives its flush
   wire rx_push    = rx_char_valid & ~asleep & ~enter;
   wire fifo_pop   = data_op16 & fifo_valid;
   wire fifo_flush = clear_all
                     | (rx_push & (~fifo_in_ready | (cfg_q.fifo_disable & fifo_valid)));

   uifs_rx_fifo #(
      .WIDTH ($bits(uifs_pkg::uifs_rx_word_type)),
      .DEPTH (RX_FIFO_DEPTH)
   ) u_rx_fifo (
      .clock     (clock),
      .rst_b     (rst_b),
      .flush     (fifo_flush),
      .in_valid  (rx_push),
      .in_ready  (fifo_in_ready),
      .in_data   (rx_char),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_head)
   );

   // parity flag from the oldest word
   wire pr_flag   = cfg_q.parity_enable & fifo_valid & fifo_head.parity;
   wire [7:0] rx_data = fifo_valid ? fifo_head.data : 8'h00;
   wire cts_state = ~pin_q[uifs_pkg::PIN_CTS_N];
   wire [15:0] status_word = {fifo_valid, ~tx_full_q, uifs_pkg::DW_ZEROS,
                              act_fe_q, cts_state, pr_flag, rx_data};

   wire irq_any = (pr_flag & cfg_q.parity_irq_mask)          // oldest parity
                | (fifo_valid & cfg_q.data_waiting_mask)      // data waiting
                | (act_fe_q & cfg_q.activity_mask)
                | (tx_src_q & cfg_q.tx_empty_mask);

   // Serial shift in on rising, out on falling edges
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         bit_cnt_q <= uifs_pkg::CNT_ZERO;
         in_sr_q   <= '0;
         out_sr_q  <= '0;
         dout_q    <= 1'b0;
      end else if (cs_fall) begin
         // Status is snapshotted at select so the word stays coherent
         bit_cnt_q <= uifs_pkg::CNT_ZERO;
         out_sr_q  <= status_word;
         dout_q    <= status_word[15];
      end else if (take_bit) begin
         bit_cnt_q <= uifs_pkg::BIT_CNT_W'(bit_cnt_q + 1'b1);
         in_sr_q   <= word_d;
         if (cfg_read) begin
            out_sr_q[14:1] <= cfg_q;
         end
      end else if (in_frame && sclk_fall) begin
         out_sr_q <= {out_sr_q[14:0], 1'b0};
         dout_q   <= out_sr_q[14];
      end
   end

   // Settings and handshake output
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cfg_q   <= uifs_pkg::CFG_RESET;
         rts_n_q <= 1'b1;
      end else begin
         // settings taken in any power state
         if (cfg_wr) begin
            cfg_q <= new_cfg;
         end
         if (data_wr) begin
            rts_n_q <= ~in_sr_q[uifs_pkg::DIN_RTS];
         end
      end
   end

   // Transmit buffer and its empty interrupt source
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tx_full_q <= 1'b0;
         tx_char_q <= '0;
         tx_src_q  <= 1'b0;
      end else begin
         // shutdown or reset empties the buffer
         if (clear_all) begin
            tx_full_q <= 1'b0;
            tx_char_q <= '0;
         end else if (data_wr && !in_sr_q[uifs_pkg::DIN_TE_N] && !asleep) begin
            tx_full_q <= 1'b1;
            tx_char_q <= in_sr_q[8:0];
         end else if (tx_take) begin
            tx_full_q <= 1'b0;
         end
         // set on emptying, wins over clear
         if (tx_take) begin
            tx_src_q <= 1'b1;
         end else if (data_op16 || cfg_wr) begin
            tx_src_q <= 1'b0;
         end
      end
   end

   // Activity in shutdown, framing error otherwise
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         act_fe_q <= 1'b0;
      end else if (enter || leave) begin
         act_fe_q <= 1'b0;
      end else if (asleep && rx_edge) begin
         act_fe_q <= 1'b1;
      end else if (!asleep && rx_char_valid) begin
         act_fe_q <= rx_frame_err;
      end else if (cfg_wr) begin
         // Configuration clear loses to a same-cycle event
         act_fe_q <= 1'b0;
      end
   end

   // Power state, oscillator control and interrupt output
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pwr_q       <= uifs_pkg::UIFS_PWR_RUN;
         abort_q     <= 1'b0;
         sleep_q     <= 1'b0;
         osc_run_q   <= 1'b1;
         osc_ready_q <= 1'b0;
         osc_cnt_q   <= '0;
         irq_n_q     <= 1'b1;
      end else begin
         pwr_q     <= pwr_d;
         // immediate abort on the hardware line
         abort_q   <= enter & hw_low;
         sleep_q   <= (pwr_d == uifs_pkg::UIFS_PWR_SLEEP);
         osc_run_q <= (pwr_d != uifs_pkg::UIFS_PWR_SLEEP);
         // Start-up wait; early characters may still be garbled
         if (pwr_d == uifs_pkg::UIFS_PWR_SLEEP) begin
            osc_cnt_q   <= '0;
            osc_ready_q <= 1'b0;
         end else if (osc_cnt_q != OSC_W'(OSC_START_CYCLES)) begin
            osc_cnt_q   <= OSC_W'(osc_cnt_q + 1'b1);
         end else begin
            osc_ready_q <= 1'b1;
         end
         // released once all causes are gone
         irq_n_q <= ~irq_any;
      end
   end

   // Outputs straight from registers
   assign dout         = dout_q;
   assign tx_valid     = tx_full_q;
   assign tx_char      = tx_char_q;
   assign tx_abort     = abort_q;
   assign rts_n        = rts_n_q;
   assign irq_n        = irq_n_q;
   assign osc_run      = osc_run_q;
   assign osc_ready    = osc_ready_q;
   assign sleep_status = sleep_q;
   assign cfg          = cfg_q;

   // Checks on the block's own behaviour
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   property p_parity_flag;
      (fifo_valid && fifo_head.parity && cfg_q.parity_enable && cfg_q.parity_irq_mask)
         |=> !irq_n;
   endproperty
   a_parity_flag: assert property (p_parity_flag) else $error("parity source lost");

   property p_parity_off;
      !cfg_q.parity_enable |-> !pr_flag;
   endproperty
   a_parity_off: assert property (p_parity_off) else $error("parity flag while off");

   property p_data_irq;
      (fifo_valid && cfg_q.data_waiting_mask) |=> !irq_n;
   endproperty
   a_data_irq: assert property (p_data_irq) else $error("data interrupt missing");

   sequence s_asleep_edge;
      asleep && rx_edge && !leave;
   endsequence
   property p_activity;
      s_asleep_edge |=> act_fe_q;
   endproperty
   a_activity: assert property (p_activity) else $error("activity not flagged");

   property p_frame_err;
      (pwr_q == uifs_pkg::UIFS_PWR_RUN && !enter && !cfg_wr && rx_char_valid && rx_frame_err)
         |=> act_fe_q;
   endproperty
   a_frame_err: assert property (p_frame_err) else $error("framing error not flagged");

   property p_tx_src_set;
      tx_take |=> tx_src_q;
   endproperty
   a_tx_src_set: assert property (p_tx_src_set) else $error("empty source not set");

   property p_tx_src_clr;
      (data_op16 && !tx_take) |=> !tx_src_q;
   endproperty
   a_tx_src_clr: assert property (p_tx_src_clr) else $error("empty source not cleared");

   property p_hw_sleep;
      (!asleep && hw_low) |=> (asleep && tx_abort && !tx_valid) ##1 !osc_run;
   endproperty
   a_hw_sleep: assert property (p_hw_sleep) else $error("hardware shutdown late");

   property p_drain;
      (pwr_q == uifs_pkg::UIFS_PWR_DRAIN && !hw_low && (tx_full_q || tx_shift_busy))
         |=> !asleep;
   endproperty
   a_drain: assert property (p_drain) else $error("shutdown before drain");

   property p_status;
      (asleep && !leave) |=> sleep_status;
   endproperty
   a_status: assert property (p_status) else $error("shutdown status missing");

   property p_entry_clear;
      enter |=> (!fifo_valid && !act_fe_q && !tx_full_q && tx_char_q == '0);
   endproperty
   a_entry_clear: assert property (p_entry_clear) else $error("entry left state");

   sequence s_wake;
      asleep && cfg_wr && !new_cfg.sw_sleep_request && !hw_low;
   endsequence
   property p_wake;
      s_wake |=> ##1 (osc_run && !osc_ready);
   endproperty
   a_wake: assert property (p_wake) else $error("oscillator not restarted");

   property p_irq_level;
      irq_any |=> !irq_n;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt not driven");
endmodule

/* File: src/uifs_pkg.sv */
// Shared constants, types and encodings for the UART status and shutdown block
package uifs_pkg;

   // Core clock rate and oscillator start-up time
   localparam int CLK_HZ        = 20_000_000;
   localparam int OSC_START_MS  = 25;
   // Least time, so whole cycles are rounded up (exact at this rate)
   localparam int OSC_START_CYC = (OSC_START_MS * CLK_HZ + 999) / 1000;

   // Receive FIFO depth and serial word length
   localparam int FIFO_DEPTH = 8;
   localparam int WORD_BITS  = 16;
   localparam int BIT_CNT_W  = 5;

   // Rising edge counts within one serial frame
   localparam logic [BIT_CNT_W-1:0] CNT_ZERO     = 5'h00;
   localparam logic [BIT_CNT_W-1:0] CNT_CMD_DONE = 5'h01;
   localparam logic [BIT_CNT_W-1:0] CNT_LAST     = 5'h0f;
   localparam logic [BIT_CNT_W-1:0] CNT_FULL     = 5'h10;

   // Synchronised pin vector layout and idle levels
   localparam int PIN_SCLK  = 0;
   localparam int PIN_CS_N  = 1;
   localparam int PIN_DIN   = 2;
   localparam int PIN_HW_N  = 3;
   localparam int PIN_RX    = 4;
   localparam int PIN_CTS_N = 5;
   localparam int PIN_N     = 6;
   localparam logic [PIN_N-1:0] PIN_IDLE = 6'h3a;

   // Data word fields, host to device
   localparam int DIN_TE_N = 10;
   localparam int DIN_RTS  = 9;

   // Serial command codes in the two top bits
   typedef enum logic [1:0] {
      UIFS_RD_DATA = 2'b00,
      UIFS_RD_CFG  = 2'b01,
      UIFS_WR_DATA = 2'b10,
      UIFS_WR_CFG  = 2'b11
   } uifs_cmd_type;

   // Power sequencing states
   typedef enum logic [1:0] {
      UIFS_PWR_RUN   = 2'b00,
      UIFS_PWR_DRAIN = 2'b01,
      UIFS_PWR_SLEEP = 2'b10
   } uifs_pwr_type;

   // One character: parity bit above eight data bits
   typedef struct packed {
      logic       parity;
      logic [7:0] data;
   } uifs_rx_word_type;

   // Configuration word, bits 13 down to 0 of a configuration frame
   typedef struct packed {
      logic       fifo_disable;
      logic       sw_sleep_request;
      logic       tx_empty_mask;
      logic       data_waiting_mask;
      logic       parity_irq_mask;
      logic       activity_mask;
      logic       infrared_mode;
      logic       stop_bit_count;
      logic       parity_enable;
      logic       word_length;
      logic [3:0] baud_divisor_code;
   } uifs_cfg_type;

   // Everything cleared, FIFO enabled at power-up
   localparam uifs_cfg_type CFG_RESET = 14'h0000;
   localparam logic [2:0]   DW_ZEROS  = 3'h0;

endpackage

/* File: src/uifs_rx_fifo.sv */
// Receive FIFO with registered head word and flush
`timescale 1ns/10ps
module uifs_rx_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input  wire logic             clock,
   input  wire logic             rst_b,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   // Pointers wrap naturally, so depth must be a power of two
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("uifs_rx_fifo: DEPTH must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];   // Storage, no reset needed
   logic [AW-1:0]    wr_q;            // Write index
   logic [AW-1:0]    rd_q;            // Read index
   logic [AW:0]      cnt_q;           // Words held
   logic [WIDTH-1:0] head_q;          // Registered oldest word

   // Flush may coincide with a push; the pushed word survives
   wire              push    = in_valid & (in_ready | flush);
   wire              pop     = out_valid & out_ready & ~flush;
   wire [AW-1:0]     wr_base = flush ? '0 : wr_q;
   wire [AW-1:0]     rd_d    = flush ? '0 : AW'(rd_q + AW'(pop));
   wire [AW:0]       remain  = flush ? '0 : (AW+1)'(cnt_q - (AW+1)'(pop));
   wire [AW:0]       cnt_d   = (AW+1)'(remain + (AW+1)'(push));
   wire [WIDTH-1:0]  head_d  = (push && remain == '0) ? in_data : mem_q[rd_d];

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = head_q;

   // Memory write port
   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wr_base] <= in_data;
      end
   end

   // Pointers, count and head register
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wr_q   <= '0;
         rd_q   <= '0;
         cnt_q  <= '0;
         head_q <= '0;
      end else begin
         wr_q   <= push ? AW'(wr_base + 1'b1) : wr_base;
         rd_q   <= rd_d;
         cnt_q  <= cnt_d;
         head_q <= head_d;
      end
   end
endmodule

/* File: tb/uifs_host.sv */
// Host model that drives the block's serial port
`timescale 1ns/10ps
module uifs_host (
   input  wire logic clock,
   input  wire logic dout,
   output logic      sclk,
   output logic      cs_n,
   output logic      din
);
   // Idle levels, serial clock stands still outside frames
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din  = 1'b1;
   end
   // One 16-bit frame, MSB first, 400 ns serial clock
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      @(negedge clock);
      cs_n = 1'b0;
      repeat (8) @(negedge clock);
      for (int i = 15; i >= 0; i--) begin
         // Data moves while sclk is low
         din = w[i];
         repeat (4) @(negedge clock);
         sclk = 1'b1;
         // Late sample: dout settles well after the fall
         repeat (4) @(negedge clock);
         r[i] = dout;
         sclk = 1'b0;
      end
      repeat (4) @(negedge clock);
      cs_n = 1'b1;
      // Released line must not keep the last bit
      din = ~din;
      repeat (8) @(negedge clock);
   endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the interrupt, FIFO and shutdown block
`timescale 1ns/10ps
module tb;
   logic                       clock, rst_b, sclk, cs_n, din, dout;
   logic                       hw_sleep_n, rx_line, cts_n;
   logic                       rx_char_valid, rx_frame_err, tx_take, tx_shift_busy;
   uifs_pkg::uifs_rx_word_type rx_char, tx_char;
   logic                       tx_valid, tx_abort, rts_n, irq_n;
   logic                       osc_run, osc_ready, sleep_status;
   uifs_pkg::uifs_cfg_type     cfg;
   logic [15:0]                rd;          // Last word read back
   int                         mismatches, n_checks;
   // Short start-up count keeps the run brief
   uifs_core #(.OSC_START_CYCLES(20), .RX_FIFO_DEPTH(8)) uifs_core_i (
      .clock(clock), .rst_b(rst_b), .sclk(sclk), .cs_n(cs_n), .din(din),
      .dout(dout), .hw_sleep_n(hw_sleep_n), .rx_line(rx_line), .cts_n(cts_n),
      .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_frame_err(rx_frame_err),
      .tx_take(tx_take), .tx_shift_busy(tx_shift_busy), .tx_valid(tx_valid),
      .tx_char(tx_char), .tx_abort(tx_abort), .rts_n(rts_n), .irq_n(irq_n),
      .osc_run(osc_run), .osc_ready(osc_ready), .sleep_status(sleep_status),
      .cfg(cfg));
   uifs_host uifs_host_i (.clock(clock), .dout(dout), .sclk(sclk), .cs_n(cs_n),
      .din(din));
   // 20 MHz core clock
   always #25 clock = ~clock;
   // Verdict and end of run
   task automatic wrap_up();
      if (mismatches == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Word comparison
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   // Single-bit comparison
   task automatic cb(input string n, input logic e, input logic g);
      chk(n, {15'h0000, e}, {15'h0000, g});
   endtask
   // Frame plus settling time for its effects
   task automatic op(input logic [15:0] w);
      uifs_host_i.xfer(w, rd);
      repeat (4) @(negedge clock);
   endtask
   // One character from the receiver core
   task automatic rx(input logic [8:0] c, input logic fe);
      rx_char_valid = 1'b1;
      rx_char = c;
      rx_frame_err = fe;
      @(negedge clock);
      rx_char_valid = 1'b0;
      rx_frame_err = 1'b0;
      repeat (4) @(negedge clock);
   endtask
   // Transmitter takes the buffer word
   task automatic take();
      tx_take = 1'b1;
      @(negedge clock);
      tx_take = 1'b0;
      repeat (4) @(negedge clock);
   endtask
   // Bounded wait: 0 sleep status, 1 oscillator ready, 2 abort pulse
   task automatic wfor(input int k, input logic v);
      logic s;
      for (int i = 0; i < 200; i++) begin
         @(negedge clock);
         s = (k == 0) ? sleep_status : (k == 1) ? osc_ready : tx_abort;
         if (s === v) return;
      end
      mismatches++;
      $display("mismatch wait%0d exp %b got %b", k, v, s);
      wrap_up();
   endtask
   // Main sequence
   initial begin
      clock = 1'b0; rst_b = 1'b0; hw_sleep_n = 1'b1; rx_line = 1'b1; cts_n = 1'b1;
      rx_char_valid = 1'b0; rx_char = 9'h000; rx_frame_err = 1'b0;
      tx_take = 1'b0; tx_shift_busy = 1'b0;
      repeat (10) @(negedge clock);
      rst_b = 1'b1;
      repeat (4) @(negedge clock);
      chk("rst", 16'h0005, {13'h0000, irq_n, sleep_status, osc_run});
      chk("cfg", 16'h0000, {2'h0, cfg});
      op(16'hc220); op(16'h4000); chk("cfgrd", 16'h4220, rd);
      rx(9'h1a5, 1'b0); cb("irq", 1'b0, irq_n);
      op(16'h0000); chk("rd", 16'hc1a5, rd); cb("irq", 1'b1, irq_n);
      rx(9'h05a, 1'b0); cb("irq", 1'b1, irq_n);
      op(16'h0000); chk("rd", 16'hc05a, rd);
      op(16'hc200); rx(9'h1a5, 1'b0); cb("irq", 1'b1, irq_n);
      op(16'h0000); chk("rd", 16'hc0a5, rd);
      op(16'hc400); rx(9'h011, 1'b0); rx(9'h022, 1'b0); cb("irq", 1'b0, irq_n);
      op(16'h0000); chk("rd", 16'hc011, rd); cb("irq", 1'b0, irq_n);
      op(16'h0000); chk("rd", 16'hc022, rd); cb("irq", 1'b1, irq_n);
      // Ninth word overflows the eight-word queue
      op(16'hc000);
      for (int i = 0; i < 9; i++) rx({1'b0, 8'h30 + 8'(i)}, 1'b0);
      op(16'h0000); chk("ovf", 16'hc038, rd);
      op(16'h0000); chk("ovf", 16'h4000, rd);
      op(16'he000); op(16'h4000); chk("cfgrd", 16'h6000, rd);
      rx(9'h041, 1'b0); rx(9'h042, 1'b0);
      op(16'h0000); chk("nofifo", 16'hc042, rd);
      op(16'h0000); chk("nofifo", 16'h4000, rd);
      op(16'hc100); rx(9'h077, 1'b1); cb("irq", 1'b0, irq_n);
      op(16'h0000); chk("fe", 16'h0400, rd & 16'h0400);
      rx(9'h078, 1'b0); cb("irq", 1'b1, irq_n);
      op(16'hc800); op(16'h8155); chk("tx", 16'h0355, {6'h00, tx_valid, tx_char});
      cb("irq", 1'b1, irq_n); take(); cb("irq", 1'b0, irq_n);
      op(16'h0000); chk("t", 16'h4000, rd & 16'h4000); cb("irq", 1'b1, irq_n);
      op(16'h8600); chk("rts", 16'h0000, {14'h0000, rts_n, tx_valid});
      op(16'hc000); cb("rts", 1'b0, rts_n);
      // Software sleep must wait for both transmit stages
      tx_shift_busy = 1'b1; op(16'hd100); op(16'h8112); rx(9'h033, 1'b0);
      repeat (20) @(negedge clock); cb("slp", 1'b0, sleep_status);
      tx_shift_busy = 1'b0; repeat (10) @(negedge clock); cb("slp", 1'b0, sleep_status);
      take(); wfor(0, 1'b1);
      chk("slp", 16'h0004, {13'h0000, sleep_status, osc_run, tx_char.parity});
      op(16'h0000); chk("slprd", 16'h4000, rd);
      cts_n = 1'b0; rx_line = 1'b0; repeat (10) @(negedge clock); cb("irq", 1'b0, irq_n);
      op(16'h0000); chk("act", 16'h0600, rd & 16'h0600);
      op(16'hd00f); chk("cfg", 16'h100f, {2'h0, cfg}); cb("slp", 1'b1, sleep_status);
      op(16'hc000); chk("wake", 16'h0002, {14'h0000, osc_run, osc_ready});
      cb("slp", 1'b0, sleep_status); wfor(1, 1'b1);
      op(16'h8044); cb("txv", 1'b1, tx_valid); hw_sleep_n = 1'b0; wfor(2, 1'b1);
      repeat (2) @(negedge clock); chk("hw", 16'h0002, {14'h0000, sleep_status, osc_run});
      hw_sleep_n = 1'b1; op(16'hc000); wfor(1, 1'b1);
      wrap_up();
   end
endmodule
